// file: gpwk_port.sv
// What this block does
// (RL1) Bit n of every port register controls pin n of eight.
// (RL2) Data read returns the latch for pins with direction one.
// (RL3) Data read returns the sampled pin level for direction zero.
// (RL4) Direction one drives the latch onto the pin; zero releases it.
// (RL5) Direction register is write only and reads as all ones.
// (RL6) Latch and direction act only while mode and segment leave general I/O.
// (RL7) Pull-up on only with direction zero and pull-up bit one.
// (RL8) Reset clears data, direction, pull-up and mode registers to zero.
// (RL9) Mode bit one makes the pin an active-low wake-up input.
// (RL10) Segment field top bit one turns every pin into a segment output.
// (RL11) Pins float in reset and standby, hold in sleep modes, work otherwise.
// (RL12) In standby an enabled pull-up keeps the pin high.
// (RL13) Latch and direction ignored while another function owns the pin.
// (RL14) Writes reach pins next edge; pin inputs pass two flip-flops.
`timescale 1ns/1ps
`default_nettype none
`include "gpwk_map.svh"
module gpwk_port #(
   parameter int ADDR_W = 18
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] general_io_pin_i,
   output logic [7:0] general_io_pin_o,
   output logic [7:0] general_io_pin_oe,
   output logic [7:0] general_io_pin_pullup,
   input wire logic [7:0] segment_drive_output,
   output logic [7:0] wakeup_input_select_n
);
   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (ADDR_W < `GPWK_ADDR_BITS || ADDR_W > 32)
      $error("gpwk_port: ADDR_W must be 18 to 32");

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0] pin_function_mode_reg;
   logic [7:0] port_output_latch_reg;
   logic [7:0] pin_pullup_enable_reg;
   logic [7:0] pin_direction_reg;
   logic [`GPWK_SEG_W-1:0] segment_group_select_reg;
   logic [`GPWK_PWR_W-1:0] power_mode_reg;
   logic [7:0] pin_meta_reg;
   logic [7:0] pin_level_reg;
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_lane0;
   logic rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [7:0] rd_data;
   gpwk_pkg::gpwk_sel_t wr_sel;
   gpwk_pkg::gpwk_sel_t rd_sel;
   gpwk_pkg::gpwk_pwr_t pwr;
   logic seg_take;
   logic do_wr;

   // ----------------------------------------------------------------
   // Decode functions
   // ----------------------------------------------------------------
   // Address to register; the same map serves reads and writes
   function automatic gpwk_pkg::gpwk_sel_t reg_select(input logic [ADDR_W-1:0] addr);
      logic [15:0] idx;
      logic high_zero;
      idx = addr[`GPWK_IDX_MSB:`GPWK_IDX_LSB];
      high_zero = ((addr >> `GPWK_ADDR_BITS) == '0);
      if (!high_zero)
         return gpwk_pkg::GPWK_SEL_NONE;
      else if (idx == `GPWK_IDX_FMODE)
         return gpwk_pkg::GPWK_SEL_FMODE;
      else if (idx == `GPWK_IDX_LATCH)
         return gpwk_pkg::GPWK_SEL_LATCH;
      else if (idx == `GPWK_IDX_PULLUP)
         return gpwk_pkg::GPWK_SEL_PULLUP;
      else if (idx == `GPWK_IDX_DIR)
         return gpwk_pkg::GPWK_SEL_DIR;
      else if (idx == `GPWK_IDX_LCDCTL)
         return gpwk_pkg::GPWK_SEL_LCDCTL;
      else if (idx == `GPWK_IDX_PWR)
         return gpwk_pkg::GPWK_SEL_PWR;
      else
         return gpwk_pkg::GPWK_SEL_NONE;
   endfunction

   // Power code to one-hot mode; unknown codes count as active
   function automatic gpwk_pkg::gpwk_pwr_t pwr_decode(input logic [`GPWK_PWR_W-1:0] code);
      case (code)
         `GPWK_PWR_SUBACTIVE: return gpwk_pkg::GPWK_SUBACTIVE;
         `GPWK_PWR_SLEEP: return gpwk_pkg::GPWK_SLEEP;
         `GPWK_PWR_SUBSLEEP: return gpwk_pkg::GPWK_SUBSLEEP;
         `GPWK_PWR_WATCH: return gpwk_pkg::GPWK_WATCH;
         `GPWK_PWR_STANDBY: return gpwk_pkg::GPWK_STANDBY;
         default: return gpwk_pkg::GPWK_ACTIVE;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   gpwk_axil_slave #(
      .ADDR_W(ADDR_W)
   ) u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_lane0(wr_lane0),
      .wr_err(wr_sel == gpwk_pkg::GPWK_SEL_NONE),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_sel == gpwk_pkg::GPWK_SEL_NONE)
   );

   assign wr_sel = reg_select(wr_addr);
   assign rd_sel = reg_select(rd_addr);
   // Byte lane 0 carries every register; other lanes are ignored
   assign do_wr = wr_en && wr_lane0;
   assign pwr = pwr_decode(power_mode_reg);
   // (RL10) segment takeover select
   assign seg_take = segment_group_select_reg[`GPWK_SEG_TAKE_BIT];

   // ----------------------------------------------------------------
   // Port registers
   // ----------------------------------------------------------------
   // (RL8) reset clears port registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_function_mode_reg <= `GPWK_RST_BYTE;
         port_output_latch_reg <= `GPWK_RST_BYTE;
         pin_pullup_enable_reg <= `GPWK_RST_BYTE;
         pin_direction_reg <= `GPWK_RST_BYTE;
      end
      else if (do_wr)
      begin
         if (wr_sel == gpwk_pkg::GPWK_SEL_FMODE)
            pin_function_mode_reg <= wr_data;
         if (wr_sel == gpwk_pkg::GPWK_SEL_LATCH)
            port_output_latch_reg <= wr_data;
         if (wr_sel == gpwk_pkg::GPWK_SEL_PULLUP)
            pin_pullup_enable_reg <= wr_data;
         if (wr_sel == gpwk_pkg::GPWK_SEL_DIR)
            pin_direction_reg <= wr_data;
      end
   end

   // Segment select and power mode, held apart from the port registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         segment_group_select_reg <= `GPWK_RST_SEG;
         power_mode_reg <= `GPWK_RST_PWR;
      end
      else if (do_wr)
      begin
         if (wr_sel == gpwk_pkg::GPWK_SEL_LCDCTL)
            segment_group_select_reg <= wr_data[`GPWK_SEG_W-1:0];
         if (wr_sel == gpwk_pkg::GPWK_SEL_PWR)
            power_mode_reg <= wr_data[`GPWK_PWR_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Pin input synchroniser
   // ----------------------------------------------------------------
   // (RL14) two-stage synchroniser; only the second stage is read
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_meta_reg <= `GPWK_RST_BYTE;
         pin_level_reg <= `GPWK_RST_BYTE;
      end
      else if (ce)
      begin
         pin_meta_reg <= general_io_pin_i;
         pin_level_reg <= pin_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Unmapped reads return zero alongside the error response
   always_comb
   begin
      rd_data = `GPWK_RST_BYTE;
      if (rd_sel == gpwk_pkg::GPWK_SEL_FMODE)
         rd_data = pin_function_mode_reg;
      else if (rd_sel == gpwk_pkg::GPWK_SEL_LATCH)
         // (RL2) (RL3) latch or pin per direction bit
         rd_data = (pin_direction_reg & port_output_latch_reg) |
            (~pin_direction_reg & pin_level_reg);
      else if (rd_sel == gpwk_pkg::GPWK_SEL_PULLUP)
         rd_data = pin_pullup_enable_reg;
      else if (rd_sel == gpwk_pkg::GPWK_SEL_DIR)
         // (RL5) write-only, reads all ones
         rd_data = `GPWK_DIR_READ;
      else if (rd_sel == gpwk_pkg::GPWK_SEL_LCDCTL)
         rd_data = {{(8-`GPWK_SEG_W){1'b0}}, segment_group_select_reg};
      else if (rd_sel == gpwk_pkg::GPWK_SEL_PWR)
         rd_data = {{(8-`GPWK_PWR_W){1'b0}}, power_mode_reg};
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // (RL4) (RL6) (RL7) (RL11) (RL12) (RL13) per-pin ownership and power states
   gpwk_pin_ctrl #(
      .PIN_COUNT(8)
   ) u_pins (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .latch(port_output_latch_reg),
      .dir(pin_direction_reg),
      .pullup_en(pin_pullup_enable_reg),
      .fmode(pin_function_mode_reg),
      .seg_take(seg_take),
      .pwr(pwr),
      .seg_data(segment_drive_output),
      .pin_out(general_io_pin_o),
      .pin_oe(general_io_pin_oe),
      .pin_pullup(general_io_pin_pullup)
   );

   // ----------------------------------------------------------------
   // Wake-up inputs
   // ----------------------------------------------------------------
   // (RL9) active-low wake input follows the synced pin when selected
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wakeup_input_select_n <= ~`GPWK_RST_BYTE;
      else if (ce)
         wakeup_input_select_n <= seg_take ? ~`GPWK_RST_BYTE :
            (pin_level_reg | ~pin_function_mode_reg);
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic live_q;
   assign live_q = (pwr == gpwk_pkg::GPWK_ACTIVE) || (pwr == gpwk_pkg::GPWK_SUBACTIVE);

   sequence s_dir_read;
      rd_en && rd_sel == gpwk_pkg::GPWK_SEL_DIR;
   endsequence
   sequence s_answer_ones;
      s_axi_rvalid && s_axi_rdata[7:0] == `GPWK_DIR_READ;
   endsequence
   // (RL5) direction reads all ones
   a_dir_read_ones: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
      s_dir_read |=> s_answer_ones)
      else $error("direction read did not return all ones");

   // (RL2) latch returned for output pins
   a_read_latch_out: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
      rd_en && rd_sel == gpwk_pkg::GPWK_SEL_LATCH |=>
      ((s_axi_rdata[7:0] & $past(pin_direction_reg)) ==
       ($past(port_output_latch_reg) & $past(pin_direction_reg))))
      else $error("output pin read did not return latch");

   // (RL3) pin level returned for input pins
   a_read_pin_in: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      rd_en && rd_sel == gpwk_pkg::GPWK_SEL_LATCH |=>
      ((s_axi_rdata[7:0] & ~$past(pin_direction_reg)) ==
       ($past(pin_level_reg) & ~$past(pin_direction_reg))))
      else $error("input pin read did not return pin level");

   // (RL8) reset clears the four port registers and floats pins
   a_reset_clear: assert property (@(posedge aclk) // RL8
      !aresetn |=> port_output_latch_reg == '0 && pin_direction_reg == '0 &&
      pin_pullup_enable_reg == '0 && pin_function_mode_reg == '0 &&
      general_io_pin_oe == '0 && general_io_pin_pullup == '0)
      else $error("reset left a register or pin active");

   // (RL4) (RL6) GPIO output drives latch
   a_gpio_drive: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
      ce && live_q && !seg_take |=>
      general_io_pin_oe == $past(pin_direction_reg & ~pin_function_mode_reg) &&
      ((general_io_pin_o ^ $past(port_output_latch_reg)) & general_io_pin_oe) == '0)
      else $error("gpio drive did not follow direction and latch");

   // (RL10) (RL13) segment takes every pin
   a_seg_override: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
      ce && live_q && seg_take |=>
      general_io_pin_oe == 8'hff && general_io_pin_o == $past(segment_drive_output))
      else $error("segment select did not take the pins");

   // (RL7) pull-up gating
   a_pullup_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
      ce && (live_q || pwr == gpwk_pkg::GPWK_STANDBY) |=>
      general_io_pin_pullup == $past(pin_pullup_enable_reg & ~pin_direction_reg))
      else $error("pull-up not gated by direction");

   // (RL11) (RL12) standby floats drivers but keeps pull-ups
   a_standby_hiz: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
      ce && pwr == gpwk_pkg::GPWK_STANDBY |=> general_io_pin_oe == '0 ##0
      (general_io_pin_pullup == $past(pin_pullup_enable_reg & ~pin_direction_reg)))
      else $error("standby did not float the pins");

   // (RL11) sleep, subsleep and watch retain pin state
   a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
      (pwr == gpwk_pkg::GPWK_SLEEP || pwr == gpwk_pkg::GPWK_SUBSLEEP ||
       pwr == gpwk_pkg::GPWK_WATCH) && $stable(pwr) |=>
      $stable(general_io_pin_oe) && $stable(general_io_pin_o) &&
      $stable(general_io_pin_pullup))
      else $error("pin state changed in a retaining mode");

   // (RL14) register write visible on the pin one edge later
   a_write_next: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
      do_wr && wr_sel == gpwk_pkg::GPWK_SEL_LATCH && ce && live_q && !seg_take &&
      pin_direction_reg == 8'hff && pin_function_mode_reg == '0 ##1 ce && live_q
      |=> general_io_pin_o == $past(wr_data, 2))
      else $error("latch write did not reach the pins");

   // (RL9) (RL14) wake input follows pin three edges later: both sync stages, then its own register
   a_wake_follow: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
      ce [*3] ##0 (!seg_take && $stable(seg_take) && $stable(pin_function_mode_reg)) |->
      wakeup_input_select_n ==
      ($past(general_io_pin_i, 3) | ~pin_function_mode_reg))
      else $error("wake input did not follow the pin");
endmodule
`default_nettype wire

// file: gpwk_map.svh
`ifndef GPWK_MAP_SVH
`define GPWK_MAP_SVH
// Register indices; byte address is four times the index
`define GPWK_IDX_FMODE 16'hffcc
`define GPWK_IDX_LATCH 16'hffd8
`define GPWK_IDX_PULLUP 16'hffe2
`define GPWK_IDX_DIR 16'hffe8
`define GPWK_IDX_LCDCTL 16'hfff0
`define GPWK_IDX_PWR 16'hfff1
// Address layout
`define GPWK_IDX_LSB 2
`define GPWK_IDX_MSB 17
`define GPWK_ADDR_BITS 18
// Reset values and fixed read values
`define GPWK_RST_BYTE 8'h00
`define GPWK_RST_SEG 4'h0
`define GPWK_RST_PWR 3'h0
`define GPWK_DIR_READ 8'hff
// Field positions
`define GPWK_SEG_TAKE_BIT 3
`define GPWK_SEG_W 4
`define GPWK_PWR_W 3
// Power mode codes in the power mode register
`define GPWK_PWR_ACTIVE 3'h0
`define GPWK_PWR_SUBACTIVE 3'h1
`define GPWK_PWR_SLEEP 3'h2
`define GPWK_PWR_SUBSLEEP 3'h3
`define GPWK_PWR_WATCH 3'h4
`define GPWK_PWR_STANDBY 3'h5
// AXI responses
`define GPWK_RESP_OKAY 2'h0
`define GPWK_RESP_SLVERR 2'h2
`endif

// file: gpwk_pkg.sv
`default_nettype none
package gpwk_pkg;
   // Operating modes of the device
   typedef enum logic [5:0] {
      GPWK_ACTIVE = 6'b000001,
      GPWK_SUBACTIVE = 6'b000010,
      GPWK_SLEEP = 6'b000100,
      GPWK_SUBSLEEP = 6'b001000,
      GPWK_WATCH = 6'b010000,
      GPWK_STANDBY = 6'b100000
   } gpwk_pwr_t;
   // Register selected by an address
   typedef enum logic [6:0] {
      GPWK_SEL_NONE = 7'b0000001,
      GPWK_SEL_FMODE = 7'b0000010,
      GPWK_SEL_LATCH = 7'b0000100,
      GPWK_SEL_PULLUP = 7'b0001000,
      GPWK_SEL_DIR = 7'b0010000,
      GPWK_SEL_LCDCTL = 7'b0100000,
      GPWK_SEL_PWR = 7'b1000000
   } gpwk_sel_t;
endpackage
`default_nettype wire

// file: gpwk_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpwk_map.svh"
module gpwk_axil_slave #(
   parameter int ADDR_W = 18
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [7:0] wr_data,
   output logic wr_lane0,
   input wire logic wr_err,
   output logic rd_en,
   output logic [ADDR_W-1:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_err
);
   logic aw_got_reg;
   logic w_got_reg;
   logic ar_got_reg;
   // ----------------------------------------------------------------
   // Handshakes
   // ----------------------------------------------------------------
   // Ready drops with ce low so no beat is taken while frozen
   assign s_axi_awready = ce && !aw_got_reg && !s_axi_bvalid;
   assign s_axi_wready = ce && !w_got_reg && !s_axi_bvalid;
   assign s_axi_arready = ce && !ar_got_reg && !s_axi_rvalid;
   assign wr_en = ce && aw_got_reg && w_got_reg;
   assign rd_en = ce && ar_got_reg;
   // Write channel capture, either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `GPWK_RESP_OKAY;
         wr_addr <= '0;
         wr_data <= `GPWK_RST_BYTE;
         wr_lane0 <= 1'b0;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_reg <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_reg <= 1'b1;
            wr_data <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
         end
         if (wr_en)
         begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? `GPWK_RESP_SLVERR : `GPWK_RESP_OKAY;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // Read channel: data registered one cycle after the address is held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ar_got_reg <= 1'b0;
         rd_addr <= '0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `GPWK_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            ar_got_reg <= 1'b1;
            rd_addr <= s_axi_araddr;
         end
         if (rd_en)
         begin
            ar_got_reg <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h0, rd_data};
            s_axi_rresp <= rd_err ? `GPWK_RESP_SLVERR : `GPWK_RESP_OKAY;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: gpwk_pin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpwk_map.svh"
module gpwk_pin_ctrl #(
   parameter int PIN_COUNT = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [PIN_COUNT-1:0] latch,
   input wire logic [PIN_COUNT-1:0] dir,
   input wire logic [PIN_COUNT-1:0] pullup_en,
   input wire logic [PIN_COUNT-1:0] fmode,
   input wire logic seg_take,
   input wire gpwk_pkg::gpwk_pwr_t pwr,
   input wire logic [PIN_COUNT-1:0] seg_data,
   output logic [PIN_COUNT-1:0] pin_out,
   output logic [PIN_COUNT-1:0] pin_oe,
   output logic [PIN_COUNT-1:0] pin_pullup
);
   if (PIN_COUNT < 1 || PIN_COUNT > 8)
      $error("gpwk_pin_ctrl: PIN_COUNT must be 1 to 8");
   logic live;
   logic standby;
   // Active and subactive follow the registers; standby floats the drivers but pull-ups still follow; sleep, subsleep and watch retain
   assign live = (pwr == gpwk_pkg::GPWK_ACTIVE) || (pwr == gpwk_pkg::GPWK_SUBACTIVE);
   assign standby = (pwr == gpwk_pkg::GPWK_STANDBY);
   // (RL1) bit n serves pin n
   for (genvar n = 0; n < PIN_COUNT; n++)
   begin : g_pin
      // Per pin driver, reset puts every pin in high impedance
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            pin_out[n] <= 1'b0;
            pin_oe[n] <= 1'b0;
            pin_pullup[n] <= 1'b0;
         end
         else if (ce && standby)
         begin
            pin_oe[n] <= 1'b0;
            pin_pullup[n] <= pullup_en[n] && !dir[n];
         end
         else if (ce && live)
         begin
            pin_out[n] <= seg_take ? seg_data[n] : latch[n];
            pin_oe[n] <= seg_take || (!fmode[n] && dir[n]);
            pin_pullup[n] <= pullup_en[n] && !dir[n];
         end
      end
   end
endmodule
`default_nettype wire

// file: gpwk_board.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// Board side of the eight port pins
// ----------
module gpwk_board (
   input wire logic aclk,
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pin_pu,
   input wire logic [7:0] drv_en,
   input wire logic [7:0] drv_val,
   output logic [7:0] level
);
   logic [7:0] flt_reg = 8'h5a;
   // A floating pin wanders, so a stale value can never pass for a match
   always_ff @(posedge aclk)
   begin
      flt_reg <= ~flt_reg;
   end
   assign level = (pin_oe & pin_o) | (~pin_oe & drv_en & drv_val)
      | (~pin_oe & ~drv_en & (pin_pu | flt_reg));
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpwk_map.svh"
module tb_top;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
   logic [7:0] general_io_pin_o, general_io_pin_oe, general_io_pin_pullup, lvl, rv, d, m, pu;
   logic [7:0] segment_drive_output = 8'h00, wakeup_input_select_n, den = 8'hff, dval = 8'h00;
   int bad_count = 0;
   int samples_checked = 0;
   always #2.5 aclk = ~aclk;
   gpwk_port dut_u (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .general_io_pin_i(lvl), .general_io_pin_o, .general_io_pin_oe, .general_io_pin_pullup,
      .segment_drive_output, .wakeup_input_select_n);
   gpwk_board board_u (.aclk, .pin_o(general_io_pin_o), .pin_oe(general_io_pin_oe),
      .pin_pu(general_io_pin_pullup), .drv_en(den), .drv_val(dval), .level(lvl));
   // ----------
   // Tasks
   // ----------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Compare one byte result
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [15:0] idx, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && n < 50);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 50)
      begin
         bad_count++;
         tally_and_finish();
      end
      repeat (2) @(posedge aclk);
   endtask
   // Read: data and response taken at the edge where rvalid is seen
   task automatic rd(input logic [15:0] idx);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && n < 50);
      rv = s_axi_rdata[7:0];
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 50)
      begin
         bad_count++;
         tally_and_finish();
      end
   endtask
   // Data read mixes latch and pin level by direction
   function automatic logic [7:0] exp_rd(input logic [7:0] l, input logic [7:0] r,
      input logic [7:0] p);
      return (l & r) | (p & ~r);
   endfunction
   // ----------
   // Scenarios
   // ----------
   initial
   begin
      void'($urandom(15185));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`GPWK_IDX_FMODE);
      chk("mode", 8'h00, rv);
      rd(`GPWK_IDX_LATCH);
      chk("data", 8'h00, rv);
      rd(`GPWK_IDX_PULLUP);
      chk("pullup", 8'h00, rv);
      chk("oe", 8'h00, general_io_pin_oe);
      repeat (4)
      begin
         d = 8'($urandom);
         m = 8'($urandom);
         pu = 8'($urandom);
         dval <= 8'($urandom);
         wr(`GPWK_IDX_LATCH, d);
         wr(`GPWK_IDX_DIR, m);
         wr(`GPWK_IDX_PULLUP, pu);
         rd(`GPWK_IDX_LATCH);
         chk("data", exp_rd(d, m, dval), rv);
         chk("oe", m, general_io_pin_oe);
         chk("out", d & m, general_io_pin_o & m);
         chk("pu", pu & ~m, general_io_pin_pullup);
         rd(`GPWK_IDX_DIR);
         chk("dir", 8'hff, rv);
      end
      dval <= 8'h05;
      wr(`GPWK_IDX_DIR, 8'hff);
      wr(`GPWK_IDX_FMODE, 8'h0f);
      chk("oe", 8'hf0, general_io_pin_oe);
      // Released pins reach the wake output only after both sync stages
      repeat (2) @(posedge aclk);
      chk("wake", 8'hf5, wakeup_input_select_n);
      segment_drive_output <= 8'($urandom);
      wr(`GPWK_IDX_LCDCTL, 8'h08);
      chk("seg", segment_drive_output, general_io_pin_o);
      chk("wakeseg", 8'hff, wakeup_input_select_n);
      wr(`GPWK_IDX_LCDCTL, 8'h07);
      chk("oe", 8'hf0, general_io_pin_oe);
      wr(`GPWK_IDX_FMODE, 8'h00);
      wr(`GPWK_IDX_LATCH, 8'h3c);
      wr(`GPWK_IDX_PWR, 8'h02);
      wr(`GPWK_IDX_LATCH, 8'hc3);
      chk("hold", 8'h3c, general_io_pin_o);
      den <= 8'h00;
      wr(`GPWK_IDX_PWR, 8'h05);
      wr(`GPWK_IDX_DIR, 8'h00);
      wr(`GPWK_IDX_PULLUP, 8'hff);
      chk("stby", 8'h00, general_io_pin_oe);
      chk("stbypu", 8'hff, lvl);
      wr(`GPWK_IDX_PWR, 8'h00);
      wr(`GPWK_IDX_DIR, 8'hff);
      chk("act", 8'hc3, general_io_pin_o);
      rd(16'h0001);
      chk("resp", {6'h0, `GPWK_RESP_SLVERR}, {6'h0, rr});
      chk("rdz", 8'h00, rv);
      wr(16'h0001, 8'h55);
      chk("bresp", {6'h0, `GPWK_RESP_SLVERR}, {6'h0, br});
      tally_and_finish();
   end
endmodule
`default_nettype wire
